// ### verilog/perx_rx_decode.sv
// Receive TLP disposition, BAR window decode and type 0 config service
//
// Functional notes
// - Window 0: 32-bit, non-prefetch, at least 512 KB
// - Window 1: 32-bit doorbell, at least 16 MB
// - BAR2/3 pair: prefetchable 64-bit, at least 16 MB
// - BAR4/5 pair: non-prefetch 64-bit, at least 16 MB
// - Every BAR has its own setup register
// - 64-bit even BAR takes odd as upper
// - Merged odd setup stays RW, no effect
// - Memory read forwarded only on enable hit
// - Memory write forwarded only on enable hit
// - Config read completes enabled byte lanes
// - Config read with ECRC error dropped
// - Poisoned config write: no update, UR completion
// - Config write updates enabled byte lanes only
// - Completion: own ID, copied requester fields
// - Config write with ECRC error dropped silently
// - Type 1 config requests are UR
// - Legacy interrupt messages are malformed
// - Power management event messages are UR
// - Prefix or hints unsupported, raise error
// - Accept ASPM negative acknowledge message
// - Generated TLPs use VC0, TC copied from request
// - Max payload 128 and 256 bytes supported
// - Unlock messages acknowledged and discarded
`timescale 1ns/1ps
`default_nettype none

module perx_rx_decode #(
  parameter int CFG_WORDS_P = perx_pkg::CFG_WORDS
) (
  input  wire logic                sys_clk,
  input  wire logic                reset_n,
  input  wire logic                clkEn,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  // Received TLP from the link side
  input  wire logic                rxValid,
  input  wire perx_pkg::perx_tlp_s rxTlp,
  output logic                     rxReady,
  // Per-TLP outcome
  output logic                     dispValid,
  output perx_pkg::perx_disp_e     dispCode,
  output logic                     errEvent,
  output logic                     creditReturn,
  output logic                     aspmNakSeen,
  // Forward to application layer
  output logic                     fwdValid,
  output perx_pkg::perx_fwd_s      fwdReq,
  input  wire logic                fwdReady,
  // Completion to transmit side
  output logic                     cplValid,
  output perx_pkg::perx_cpl_s      cplOut,
  input  wire logic                cplReady,
  output logic [1:0]               maxPayload
);

  if (CFG_WORDS_P < 1 || CFG_WORDS_P > 16) begin : gBadCfgWords
    $error("CFG_WORDS_P must be 1 to 16");
  end

  localparam logic [31:0] ZERO32 = 32'h0000_0000;

  logic [31:0] barQ   [6];
  logic [31:0] setupQ [6];
  logic [31:0] cfgQ   [CFG_WORDS_P];
  logic        memEnQ;
  logic [15:0] cplIdQ;
  logic [1:0]  mpsQ;
  logic [15:0] urCntQ;
  logic [15:0] malfCntQ;
  logic [1:0]  lastDispQ;

  // Window size mask from setup size field, clamped to the least size
  function automatic logic [63:0] sizeMask(input logic [31:0] setup, input logic [4:0] minSz);
    logic [4:0] sz;
    sz = setup[perx_pkg::SETUP_SZ_LSB +: 5];
    if (sz < minSz) begin
      sz = minSz;
    end
    sizeMask = ~((64'h0000_0000_0000_0001 << sz) - 64'h0000_0000_0000_0001);
  endfunction

  // Byte-lane merge used by config writes
  function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    laneMerge = r;
  endfunction

  // Window hit decode
  logic [3:0]  winHit;
  logic [63:0] base2;
  logic [63:0] base4;
  logic [63:0] mask0, mask1;
  always_comb begin
    base2 = setupQ[2][perx_pkg::SETUP_B64_BIT] ? {barQ[3], barQ[2]} : {ZERO32, barQ[2]};
    base4 = setupQ[4][perx_pkg::SETUP_B64_BIT] ? {barQ[5], barQ[4]} : {ZERO32, barQ[4]};
    winHit = 4'h0;
    mask0 = sizeMask(setupQ[0], perx_pkg::MIN_SZ_REGS);
    winHit[0] = setupQ[0][perx_pkg::SETUP_EN_BIT] && rxTlp.addr[63:32] == ZERO32 &&
                ((rxTlp.addr[31:0] ^ barQ[0]) & mask0[31:0]) == ZERO32;
    mask1 = sizeMask(setupQ[1], perx_pkg::MIN_SZ_16M);
    winHit[1] = setupQ[1][perx_pkg::SETUP_EN_BIT] && rxTlp.addr[63:32] == ZERO32 &&
                ((rxTlp.addr[31:0] ^ barQ[1]) & mask1[31:0]) == ZERO32;
    winHit[2] = setupQ[2][perx_pkg::SETUP_EN_BIT] &&
                ((rxTlp.addr ^ base2) & sizeMask(setupQ[2], perx_pkg::MIN_SZ_16M)) == 64'h0;
    winHit[3] = setupQ[4][perx_pkg::SETUP_EN_BIT] &&
                ((rxTlp.addr ^ base4) & sizeMask(setupQ[4], perx_pkg::MIN_SZ_16M)) == 64'h0;
  end

  // Disposition of the presented TLP
  perx_pkg::perx_disp_e disp;
  logic       wantFwd;
  logic       wantCpl;
  logic       cplUr;
  logic       doCfgWr;
  logic       isErr;
  always_comb begin
    disp    = perx_pkg::DISP_ACCEPT;
    wantFwd = 1'b0;
    wantCpl = 1'b0;
    cplUr   = 1'b0;
    doCfgWr = 1'b0;
    if (rxTlp.hasPrefix || rxTlp.hasHints) begin
      disp = perx_pkg::DISP_UR;
    end else begin
      unique case (rxTlp.kind)
        perx_pkg::PERX_MRD, perx_pkg::PERX_MWR: begin
          if (memEnQ && |winHit) begin
            wantFwd = 1'b1;
          end else begin
            disp = perx_pkg::DISP_UR;
          end
        end
        perx_pkg::PERX_CPL: wantFwd = 1'b1;
        perx_pkg::PERX_CFGR0: begin
          if (rxTlp.ecrcErr) begin
            disp = perx_pkg::DISP_DISCARD;
          end else begin
            wantCpl = 1'b1;
          end
        end
        perx_pkg::PERX_CFGW0: begin
          if (rxTlp.ecrcErr) begin
            disp = perx_pkg::DISP_DISCARD;
          end else if (rxTlp.poisoned) begin
            disp    = perx_pkg::DISP_UR;
            wantCpl = 1'b1;
            cplUr   = 1'b1;
          end else begin
            wantCpl = 1'b1;
            doCfgWr = 1'b1;
          end
        end
        perx_pkg::PERX_CFGR1, perx_pkg::PERX_CFGW1: disp = perx_pkg::DISP_UR;
        perx_pkg::PERX_INTX:  disp = perx_pkg::DISP_MALF;
        perx_pkg::PERX_PME:   disp = perx_pkg::DISP_UR;
        perx_pkg::PERX_ASNAK: disp = perx_pkg::DISP_ACCEPT;
        perx_pkg::PERX_UNLK:  disp = perx_pkg::DISP_DISCARD;
        default:              disp = perx_pkg::DISP_UR;
      endcase
    end
    isErr = disp == perx_pkg::DISP_UR || disp == perx_pkg::DISP_MALF;
  end

  // Stall while the needed output slot is still occupied
  assign rxReady = clkEn && !(wantFwd && fwdValid && !fwdReady) &&
                   !(wantCpl && cplValid && !cplReady);
  logic take;
  assign take = rxValid && rxReady;

  logic [3:0] cfgIdx;
  assign cfgIdx = rxTlp.addr[5:2];
  logic cfgInRange;
  assign cfgInRange = 32'(cfgIdx) < CFG_WORDS_P;

  // Outcome pulses
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dispValid    <= 1'b0;
      dispCode     <= perx_pkg::DISP_ACCEPT;
      errEvent     <= 1'b0;
      creditReturn <= 1'b0;
      aspmNakSeen  <= 1'b0;
    end else if (clkEn) begin
      dispValid    <= take;
      dispCode     <= disp;
      errEvent     <= take && isErr;
      creditReturn <= take;
      aspmNakSeen  <= take && rxTlp.kind == perx_pkg::PERX_ASNAK && !rxTlp.hasPrefix &&
                      !rxTlp.hasHints;
    end
  end

  // Forward slot
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      fwdValid <= 1'b0;
      fwdReq   <= '0;
    end else if (clkEn) begin
      if (take && wantFwd) begin
        fwdValid       <= 1'b1;
        fwdReq.tlp     <= rxTlp;
        fwdReq.window  <= winHit[0] ? 2'd0 : winHit[1] ? 2'd1 : winHit[2] ? 2'd2 : 2'd3;
      end else if (fwdReady) begin
        fwdValid <= 1'b0;
      end
    end
  end

  // Completion slot
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cplValid <= 1'b0;
      cplOut   <= '0;
    end else if (clkEn) begin
      if (take && wantCpl) begin
        cplValid           <= 1'b1;
        cplOut.cplId       <= cplIdQ;
        cplOut.reqId       <= rxTlp.reqId;
        cplOut.tag         <= rxTlp.tag;
        cplOut.tc          <= rxTlp.tc;
        cplOut.vc          <= 3'd0;
        cplOut.unsupported <= cplUr;
        cplOut.hasData     <= rxTlp.kind == perx_pkg::PERX_CFGR0;
        cplOut.data        <= (rxTlp.kind == perx_pkg::PERX_CFGR0 && cfgInRange) ?
                              laneMerge(ZERO32, cfgQ[cfgIdx], rxTlp.be) : ZERO32;
      end else if (cplReady) begin
        cplValid <= 1'b0;
      end
    end
  end

  // APB access phase decode; zero wait states
  logic apbWr;
  logic [3:0] apbIdx;
  assign apbWr  = psel && penable && pwrite && clkEn;
  assign apbIdx = paddr[5:2];
  assign pready = 1'b1;

  // Configuration dwords, written by config TLPs or APB
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < CFG_WORDS_P; i++) begin
        cfgQ[i] <= ZERO32;
      end
    end else if (clkEn) begin
      if (take && doCfgWr && cfgInRange) begin
        cfgQ[cfgIdx] <= laneMerge(cfgQ[cfgIdx], rxTlp.data, rxTlp.be);
      end else if (apbWr && paddr[11:6] == perx_pkg::REG_CFG0[11:6] &&
                   32'(apbIdx) < CFG_WORDS_P) begin
        cfgQ[apbIdx] <= pwdata;
      end
    end
  end

  // BAR and setup registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 6; i++) begin
        barQ[i] <= ZERO32;
      end
      setupQ[0] <= perx_pkg::SETUP0_RST;
      setupQ[1] <= perx_pkg::SETUP1_RST;
      setupQ[2] <= perx_pkg::SETUP2_RST;
      setupQ[3] <= perx_pkg::SETUPX_RST;
      setupQ[4] <= perx_pkg::SETUP4_RST;
      setupQ[5] <= perx_pkg::SETUPX_RST;
    end else if (apbWr) begin
      for (int i = 0; i < 6; i++) begin
        if (paddr == perx_pkg::REG_BAR0 + 12'(4 * i)) begin
          barQ[i] <= pwdata;
        end
        if (paddr == perx_pkg::REG_SETUP0 + 12'(4 * i)) begin
          setupQ[i] <= pwdata;
          if (i < 2) begin
            setupQ[i][perx_pkg::SETUP_B64_BIT]  <= 1'b0;
            setupQ[i][perx_pkg::SETUP_PREF_BIT] <= 1'b0;
          end
          if (i == 2 || i == 4) begin
            setupQ[i][perx_pkg::SETUP_B64_BIT]  <= 1'b1;
            setupQ[i][perx_pkg::SETUP_PREF_BIT] <= i == 2;
          end
        end
      end
    end
  end

  // Command and payload select
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      memEnQ <= 1'b0;
      cplIdQ <= 16'h0000;
      mpsQ   <= perx_pkg::MPS_128;
    end else if (apbWr) begin
      if (paddr == perx_pkg::REG_CMD) begin
        memEnQ <= pwdata[0];
        cplIdQ <= pwdata[31:16];
      end
      if (paddr == perx_pkg::REG_MPS && pwdata[1:0] <= perx_pkg::MPS_256) begin
        mpsQ <= pwdata[1:0];
      end
    end
  end
  assign maxPayload = mpsQ;

  // Saturating event counts, cleared by writing the status register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      urCntQ    <= 16'h0000;
      malfCntQ  <= 16'h0000;
      lastDispQ <= 2'b00;
    end else if (clkEn) begin
      if (take) begin
        lastDispQ <= disp;
      end
      // Event wins over a clear in the same cycle
      if (take && disp == perx_pkg::DISP_UR) begin
        urCntQ <= (urCntQ == 16'hFFFF) ? urCntQ : urCntQ + 16'h0001;
      end else if (apbWr && paddr == perx_pkg::REG_STATUS) begin
        urCntQ <= 16'h0000;
      end
      if (take && disp == perx_pkg::DISP_MALF) begin
        malfCntQ <= (malfCntQ == 16'hFFFF) ? malfCntQ : malfCntQ + 16'h0001;
      end else if (apbWr && paddr == perx_pkg::REG_STATUS) begin
        malfCntQ <= 16'h0000;
      end
    end
  end

  // Read mux
  logic [31:0] rdMux;
  logic        rdHit;
  always_comb begin
    rdMux = ZERO32;
    rdHit = 1'b1;
    if (paddr == perx_pkg::REG_CMD) begin
      rdMux = {cplIdQ, 15'h0000, memEnQ};
    end else if (paddr == perx_pkg::REG_STATUS) begin
      rdMux = {urCntQ[13:0], malfCntQ[13:0], 2'b00, lastDispQ};
    end else if (paddr == perx_pkg::REG_MPS) begin
      rdMux = {30'h0000_0000, mpsQ};
    end else if (paddr >= perx_pkg::REG_BAR0 && paddr < perx_pkg::REG_BAR0 + 12'h018) begin
      rdMux = barQ[3'(apbIdx - 4'd4)];
    end else if (paddr >= perx_pkg::REG_SETUP0 && paddr < perx_pkg::REG_SETUP0 + 12'h018) begin
      rdMux = setupQ[3'(apbIdx - 4'd12)];
    end else if (paddr[11:6] == perx_pkg::REG_CFG0[11:6] && 32'(apbIdx) < CFG_WORDS_P) begin
      rdMux = cfgQ[apbIdx];
    end else begin
      rdHit = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= ZERO32;
    end else if (clkEn && psel && !penable) begin
      prdata <= rdMux;
    end
  end
  assign pslverr = psel && penable && (!rdHit || paddr[1:0] != 2'b00);

endmodule // perx_rx_decode

`default_nettype wire

// ### verilog/perx_pkg.sv
// Package: constants, types and register map of the endpoint receive decoder
package perx_pkg;

  // APB register byte offsets
  localparam logic [11:0] REG_CMD       = 12'h000; // Command: memory access enable, completer ID
  localparam logic [11:0] REG_STATUS    = 12'h004; // Sticky event counts and last-TLP outcome
  localparam logic [11:0] REG_MPS       = 12'h008; // Max payload select
  localparam logic [11:0] REG_BAR0      = 12'h010; // BAR0..BAR5 at 0x10 + 4*n
  localparam logic [11:0] REG_SETUP0    = 12'h030; // Setup0..Setup5 at 0x30 + 4*n
  localparam logic [11:0] REG_CFG0      = 12'h100; // Config dwords 0..15 at 0x100 + 4*n

  // Setup register fields
  localparam int SETUP_EN_BIT   = 31;
  localparam int SETUP_B64_BIT  = 1;
  localparam int SETUP_PREF_BIT = 0;
  localparam int SETUP_SZ_LSB   = 8;  // log2 of window size, 5 bits

  // Least window sizes as log2 of bytes
  localparam logic [4:0] MIN_SZ_REGS  = 5'd19; // 512 KB
  localparam logic [4:0] MIN_SZ_16M   = 5'd24; // 16 MB

  localparam logic [31:0] SETUP0_RST = 32'h8000_1300;
  localparam logic [31:0] SETUP1_RST = 32'h8000_1800;
  localparam logic [31:0] SETUP2_RST = 32'h8000_1803;
  localparam logic [31:0] SETUP4_RST = 32'h8000_1802;
  localparam logic [31:0] SETUPX_RST = 32'h0000_1800;

  localparam int CFG_WORDS = 16;
  localparam logic [1:0] MPS_128 = 2'd0;
  localparam logic [1:0] MPS_256 = 2'd1;

  typedef enum logic [3:0] {
    PERX_MRD   = 4'h0,
    PERX_MWR   = 4'h1,
    PERX_CPL   = 4'h2,
    PERX_CFGR0 = 4'h3,
    PERX_CFGW0 = 4'h4,
    PERX_CFGR1 = 4'h5,
    PERX_CFGW1 = 4'h6,
    PERX_INTX  = 4'h7,
    PERX_PME   = 4'h8,
    PERX_ASNAK = 4'h9,
    PERX_UNLK  = 4'hA,
    PERX_OTHER = 4'hF
  } perx_kind_e;

  typedef enum logic [1:0] {
    DISP_ACCEPT  = 2'b00,
    DISP_UR      = 2'b01,
    DISP_MALF    = 2'b10,
    DISP_DISCARD = 2'b11
  } perx_disp_e;

  // Decoded received TLP header
  typedef struct packed {
    perx_kind_e  kind;
    logic [63:0] addr;      // Memory address, or config dword index in [5:2]
    logic [15:0] reqId;
    logic [7:0]  tag;
    logic [2:0]  tc;
    logic [3:0]  be;
    logic [31:0] data;
    logic        poisoned;
    logic        ecrcErr;
    logic        hasPrefix;
    logic        hasHints;
  } perx_tlp_s;

  // Completion to the transmit side
  typedef struct packed {
    logic [15:0] cplId;
    logic [15:0] reqId;
    logic [7:0]  tag;
    logic [2:0]  tc;
    logic [2:0]  vc;
    logic        unsupported;
    logic        hasData;
    logic [31:0] data;
  } perx_cpl_s;

  // Forwarded request to the application layer
  typedef struct packed {
    perx_tlp_s  tlp;
    logic [1:0] window;
  } perx_fwd_s;

endpackage : perx_pkg

// ### verification/perx_rx_decode_sva.sv
// Port checker for the receive decoder
`timescale 1ns/1ps
`default_nettype none
module perx_rx_decode_sva (
  input wire logic                 sys_clk,
  input wire logic                 reset_n,
  input wire logic                 rxValid,
  input wire perx_pkg::perx_tlp_s  rxTlp,
  input wire logic                 rxReady,
  input wire logic                 dispValid,
  input wire perx_pkg::perx_disp_e dispCode,
  input wire logic                 errEvent,
  input wire logic                 creditReturn,
  input wire logic                 aspmNakSeen,
  input wire logic                 cplValid,
  input wire perx_pkg::perx_cpl_s  cplOut,
  input wire logic                 cplReady,
  input wire logic [1:0]           maxPayload
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic               take;
  perx_pkg::perx_kind_e k;
  logic               plain;
  assign take = rxValid && rxReady;
  // Prefix or hints turn any kind into an unsupported request
  assign plain = !rxTlp.hasPrefix && !rxTlp.hasHints;
  assign k    = rxTlp.kind;

  a_take_disp: assert property (take |=> dispValid && creditReturn)
    else $error("no disposition after take");
  a_type1_ur: assert property (take && (k == perx_pkg::PERX_CFGR1 || k == perx_pkg::PERX_CFGW1)
    |=> dispCode == perx_pkg::DISP_UR && errEvent)
    else $error("type 1 config not unsupported");
  a_intx_malf: assert property (take && plain && k == perx_pkg::PERX_INTX
    |=> dispCode == perx_pkg::DISP_MALF && errEvent)
    else $error("interrupt message not malformed");
  a_pme_ur: assert property (take && k == perx_pkg::PERX_PME
    |=> dispCode == perx_pkg::DISP_UR && errEvent)
    else $error("power event not unsupported");
  a_hint_ur: assert property (take && k == perx_pkg::PERX_MWR && (rxTlp.hasPrefix || rxTlp.hasHints)
    |=> dispCode == perx_pkg::DISP_UR && errEvent)
    else $error("prefix or hints accepted");
  a_nak_seen: assert property (take && plain && k == perx_pkg::PERX_ASNAK
    |=> aspmNakSeen && !errEvent)
    else $error("link nak not taken");
  a_unlock_quiet: assert property (take && plain && k == perx_pkg::PERX_UNLK
    |=> dispCode == perx_pkg::DISP_DISCARD && !errEvent)
    else $error("unlock not discarded quietly");
  a_rd_ecrc: assert property (take && k == perx_pkg::PERX_CFGR0 && rxTlp.ecrcErr && !cplValid
    |=> !cplValid)
    else $error("completion for bad read");
  a_wr_ecrc: assert property (take && plain && k == perx_pkg::PERX_CFGW0 && rxTlp.ecrcErr && !cplValid
    |=> !cplValid && dispCode == perx_pkg::DISP_DISCARD)
    else $error("bad config write not dropped");
  a_poison_ur: assert property (take && plain && k == perx_pkg::PERX_CFGW0 && rxTlp.poisoned
    && !rxTlp.ecrcErr && !cplValid |=> cplValid && cplOut.unsupported)
    else $error("poisoned write without unsupported completion");
  a_cpl_vc0: assert property (cplValid |-> cplOut.vc == 3'h0)
    else $error("completion not on channel zero");
  a_cpl_hold: assert property (cplValid && !cplReady |=> cplValid && $stable(cplOut))
    else $error("completion changed while stalled");
  a_mps_legal: assert property (maxPayload <= 2'h1)
    else $error("illegal payload setting");
endmodule // perx_rx_decode_sva

bind perx_rx_decode perx_rx_decode_sva perx_rx_decode_sva_i (.sys_clk(sys_clk),
  .reset_n(reset_n), .rxValid(rxValid), .rxTlp(rxTlp), .rxReady(rxReady),
  .dispValid(dispValid), .dispCode(dispCode), .errEvent(errEvent),
  .creditReturn(creditReturn), .aspmNakSeen(aspmNakSeen), .cplValid(cplValid),
  .cplOut(cplOut), .cplReady(cplReady), .maxPayload(maxPayload));
`default_nettype wire

// ### verification/perx_app_model.sv
// Application-side sink for forwarded requests and completions
`timescale 1ns/1ps
`default_nettype none
module perx_app_model (
  input wire logic                sys_clk,
  input wire logic                reset_n,
  input wire logic                fwdValid,
  input wire perx_pkg::perx_fwd_s fwdReq,
  input wire logic                cplValid,
  input wire perx_pkg::perx_cpl_s cplOut,
  output logic                    fwdReady,
  output logic                    cplReady,
  output int                      fwdCnt,
  output int                      cplCnt,
  output perx_pkg::perx_fwd_s     lastFwd,
  output perx_pkg::perx_cpl_s     lastCpl
);
  // Random stalls keep the decoder's hold logic busy
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      fwdReady <= 1'b0;
      cplReady <= 1'b0;
      fwdCnt   <= 0;
      cplCnt   <= 0;
      lastFwd  <= '0;
      lastCpl  <= '0;
    end else begin
      fwdReady <= 1'($urandom);
      cplReady <= 1'($urandom);
      if (fwdValid && fwdReady) begin
        fwdCnt  <= fwdCnt + 1;
        lastFwd <= fwdReq;
      end
      if (cplValid && cplReady) begin
        cplCnt  <= cplCnt + 1;
        lastCpl <= cplOut;
      end
    end
  end
endmodule // perx_app_model
`default_nettype wire

// ### verification/test_perx_rx_decode.sv
// Self-checking bench for the receive decoder
`timescale 1ns/1ps
`default_nettype none
module test_perx_rx_decode;
  localparam logic [15:0] CID = 16'h0A5C;
  logic sys_clk = 0, reset_n = 0, clkEn = 1, psel = 0, penable = 0, pwrite = 0, rxValid = 0;
  logic pready, pslverr, rxReady, dispValid, errEvent, creditReturn, aspmNakSeen;
  logic fwdValid, fwdReady, cplValid, cplReady, err, dv, ee;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, cv, mv;
  logic [1:0] maxPayload;
  perx_pkg::perx_tlp_s rxTlp = '0, sent;
  perx_pkg::perx_disp_e dispCode, dc;
  perx_pkg::perx_fwd_s fwdReq, lastFwd;
  perx_pkg::perx_cpl_s cplOut, lastCpl;
  int failures = 0, checks = 0, cyc = 0, fwdCnt, cplCnt, c0, f0, w;
  logic [63:0] a;
  logic [31:0] rst[6] = '{perx_pkg::SETUP0_RST, perx_pkg::SETUP1_RST, perx_pkg::SETUP2_RST,
                          perx_pkg::SETUPX_RST, perx_pkg::SETUP4_RST, perx_pkg::SETUPX_RST};
  logic [31:0] bars[6] = '{32'hF0000000, 32'hE0000000, 32'h02000000, 32'h1, 32'h04000000, 32'h2};
  logic [63:0] base[4] = '{64'hF0000000, 64'hE0000000, 64'h1_02000000, 64'h2_04000000};
  perx_pkg::perx_kind_e ks[7] = '{perx_pkg::PERX_CFGR1, perx_pkg::PERX_CFGW1, perx_pkg::PERX_INTX,
    perx_pkg::PERX_PME, perx_pkg::PERX_ASNAK, perx_pkg::PERX_UNLK, perx_pkg::PERX_MWR};
  logic [1:0] xd[7] = '{2'h1, 2'h1, 2'h2, 2'h1, 2'h0, 2'h3, 2'h1};

  perx_rx_decode perx_rx_decode_i (.sys_clk(sys_clk), .reset_n(reset_n), .clkEn(clkEn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .rxValid(rxValid), .rxTlp(rxTlp),
    .rxReady(rxReady), .dispValid(dispValid), .dispCode(dispCode), .errEvent(errEvent),
    .creditReturn(creditReturn), .aspmNakSeen(aspmNakSeen), .fwdValid(fwdValid),
    .fwdReq(fwdReq), .fwdReady(fwdReady), .cplValid(cplValid), .cplOut(cplOut),
    .cplReady(cplReady), .maxPayload(maxPayload));
  perx_app_model perx_app_model_i (.sys_clk(sys_clk), .reset_n(reset_n), .fwdValid(fwdValid),
    .fwdReq(fwdReq), .cplValid(cplValid), .cplOut(cplOut), .fwdReady(fwdReady),
    .cplReady(cplReady), .fwdCnt(fwdCnt), .cplCnt(cplCnt), .lastFwd(lastFwd),
    .lastCpl(lastCpl));

  always #2 sys_clk = ~sys_clk;

  task stop_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] n, logic [3:0] be);
    for (int b = 0; b < 4; b++)
      if (be[b])
        o[8*b+:8] = n[8*b+:8];
    return o;
  endfunction

  // Release after the answer, then one idle edge so the next call starts clean
  task apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
    psel <= 1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge sys_clk);
  endtask

  task send(input perx_pkg::perx_kind_e k, input logic [63:0] ad, input logic [3:0] be,
            input logic [31:0] d, input logic [3:0] fl);
    sent = '0;
    sent.kind = k;
    sent.addr = ad;
    sent.be = be;
    sent.data = d;
    sent.reqId = 16'($urandom);
    sent.tag = 8'($urandom);
    sent.tc = 3'($urandom);
    {sent.poisoned, sent.ecrcErr, sent.hasPrefix, sent.hasHints} = fl;
    c0 = cplCnt;
    rxValid <= 1;
    rxTlp <= sent;
    do @(posedge sys_clk); while (rxReady !== 1'b1);
    rxValid <= 0;
    @(posedge sys_clk);
    dv = dispValid;
    dc = dispCode;
    ee = errEvent;
    repeat (20) if (cplCnt == c0) @(posedge sys_clk);
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      stop_test();
    end
  end

  initial begin
    void'($urandom(32'h6880A28C));
    repeat (2) @(posedge sys_clk);
    reset_n <= 1;
    @(posedge sys_clk);
    for (int i = 0; i < 6; i++) begin
      apb(0, perx_pkg::REG_SETUP0 + 12'(4 * i), 32'h0);
      chk(rd, rst[i]);
      apb(1, perx_pkg::REG_BAR0 + 12'(4 * i), bars[i]);
      if (i != 3 && i != 5) begin
        apb(1, perx_pkg::REG_SETUP0 + 12'(4 * i), rst[i] ^ 32'h3);
        apb(0, perx_pkg::REG_SETUP0 + 12'(4 * i), 32'h0);
        chk(rd, rst[i]);
      end
    end
    apb(1, perx_pkg::REG_SETUP0 + 12'hC, 32'h80001F03);
    apb(0, perx_pkg::REG_SETUP0 + 12'hC, 32'h0);
    chk(rd, 32'h80001F03);
    apb(1, perx_pkg::REG_SETUP0 + 12'hC, 32'h0);
    apb(1, perx_pkg::REG_CMD, {CID, 16'h0001});
    $display("setup test done");
    for (int i = 0; i < 12; i++) begin
      w = $urandom % 4;
      a = base[w] + ($urandom & (w == 0 ? 32'h7FFFC : 32'hFFFFFC));
      f0 = fwdCnt;
      send(i[0] ? perx_pkg::PERX_MWR : perx_pkg::PERX_MRD, a, 4'hF, $urandom, 4'h0);
      repeat (20) if (fwdCnt == f0) @(posedge sys_clk);
      chk(dc, perx_pkg::DISP_ACCEPT);
      chk(lastFwd.window, w);
      chk(lastFwd.tlp.addr, a);
    end
    send(perx_pkg::PERX_MRD, base[0] + 64'h80000, 4'hF, 0, 4'h0);
    chk(dc, perx_pkg::DISP_UR);
    apb(1, perx_pkg::REG_SETUP0 + 12'h4, perx_pkg::SETUPX_RST);
    send(perx_pkg::PERX_MWR, base[1], 4'hF, 0, 4'h0);
    chk(dc, perx_pkg::DISP_UR);
    apb(1, perx_pkg::REG_CMD, {CID, 16'h0000});
    send(perx_pkg::PERX_MRD, base[2], 4'hF, 0, 4'h0);
    chk(dc, perx_pkg::DISP_UR);
    send(perx_pkg::PERX_MWR, base[3], 4'hF, 0, 4'h0);
    chk(dc, perx_pkg::DISP_UR);
    f0 = fwdCnt;
    send(perx_pkg::PERX_CPL, 0, 4'hF, 0, 4'h0);
    repeat (20) if (fwdCnt == f0) @(posedge sys_clk);
    chk(lastFwd.tlp.kind, perx_pkg::PERX_CPL);
    $display("window test done");
    cv = $urandom;
    mv = $urandom;
    apb(1, perx_pkg::REG_CFG0 + 12'h14, cv);
    send(perx_pkg::PERX_CFGW0, 64'h14, 4'b0101, mv, 4'h0);
    cv = merge(cv, mv, 4'b0101);
    send(perx_pkg::PERX_CFGR0, 64'h14, 4'hF, 0, 4'h0);
    chk(lastCpl.data, cv);
    send(perx_pkg::PERX_CFGR0, 64'h14, 4'b0011, 0, 4'h0);
    chk(lastCpl.data, merge(32'h0, cv, 4'b0011));
    chk({lastCpl.cplId, lastCpl.reqId, lastCpl.tag, lastCpl.tc}, {CID, sent.reqId, sent.tag, sent.tc});
    send(perx_pkg::PERX_CFGW0, 64'h14, 4'hF, ~cv, 4'b1000);
    chk({dc, lastCpl.unsupported, lastCpl.reqId}, {perx_pkg::DISP_UR, 1'b1, sent.reqId});
    send(perx_pkg::PERX_CFGW0, 64'h14, 4'hF, ~cv, 4'b0100);
    chk({dc, 32'(cplCnt)}, {perx_pkg::DISP_DISCARD, 32'(c0)});
    send(perx_pkg::PERX_CFGR0, 64'h14, 4'hF, 0, 4'b0100);
    chk(cplCnt, c0);
    apb(0, perx_pkg::REG_CFG0 + 12'h14, 32'h0);
    chk(rd, cv);
    $display("config test done");
    apb(1, perx_pkg::REG_STATUS, 32'h0);
    for (int i = 0; i < 9; i++) begin
      send(ks[i % 7], base[0], 4'hF, 0, i > 6 ? 4'(i - 6) : 4'h0);
      chk({dv, dc, ee}, {1'b1, xd[i % 7], 1'(xd[i % 7] inside {2'h1, 2'h2})});
    end
    apb(0, perx_pkg::REG_STATUS, 32'h0);
    chk(rd, {14'h0006, 14'h0001, 4'h1});
    $display("message test done");
    apb(1, perx_pkg::REG_MPS, 32'h1);
    chk(maxPayload, perx_pkg::MPS_256);
    apb(1, perx_pkg::REG_MPS, 32'h2);
    chk(maxPayload, perx_pkg::MPS_256);
    apb(1, perx_pkg::REG_MPS, 32'h0);
    chk(maxPayload, perx_pkg::MPS_128);
    apb(0, 12'h0FC, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    clkEn <= 0;
    @(posedge sys_clk);
    chk(rxReady, 1'b0);
    clkEn <= 1;
    @(posedge sys_clk);
    $display("register test done");
    stop_test();
  end
endmodule // test_perx_rx_decode
`default_nettype wire
